// ==== src/fws_map.svh ====
`ifndef FWS_MAP_SVH
`define FWS_MAP_SVH

// -----------------------------------------------------------------------
// Program store control register
// -----------------------------------------------------------------------
`define FWS_PSC_ADDR      8'h8F
`define FWS_PSC_RESET     8'h00
`define FWS_PSC_WE_BIT    0
`define FWS_PSC_EE_BIT    1

// -----------------------------------------------------------------------
// Flash geometry
// -----------------------------------------------------------------------
`define FWS_ADDR_W        15
`define FWS_PAGE_SHIFT    9
`define FWS_PAGE_W        6
`define FWS_LOCK_ADDR     15'h7FFF
`define FWS_ERASED_BYTE   8'hFF
`define FWS_BLOCKED_READ  8'h00

`endif

// ==== src/fws_pkg.sv ====
package fws_pkg;

    // Flash controller operations.
    typedef enum logic [1:0] {
        FWS_OP_NONE,
        FWS_OP_READ,
        FWS_OP_WRITE,
        FWS_OP_ERASE
    } fws_op_t;

    // Lock byte capture sequence.
    typedef enum logic [1:0] {
        FWS_ST_FETCH,
        FWS_ST_WAIT,
        FWS_ST_RUN
    } fws_state_t;

endpackage : fws_pkg

// ==== src/fws_guard_if.sv ====
`include "fws_map.svh"

// Carries the page check between the top and the page guard.
interface fws_guard_if;
    logic [`FWS_ADDR_W-1:0] addr;
    logic [7:0]             lock_byte;
    logic                   privileged;
    logic                   allow;

    modport top   (output addr, output lock_byte, output privileged,
                   input allow);
    modport guard (input addr, input lock_byte, input privileged,
                   output allow);
endinterface : fws_guard_if

// ==== src/fws_page_guard.sv ====
`include "fws_map.svh"

module fws_page_guard
    import fws_pkg::*;
(
    // Check request and answer
    fws_guard_if.guard g
);

    // -------------------------------------------------------------------
    // Page lock decode
    // -------------------------------------------------------------------
    logic [`FWS_ADDR_W-1:0] lock_addr;
    logic [`FWS_PAGE_W-1:0] page;
    logic [7:0]             locked_pages;
    logic                   in_low_run;
    logic                   in_lock_page;
    logic                   any_lock;

    // The locked count is the ones complement of the lock byte, pages from
    // zero upward; the lock byte page joins as soon as any bit is zero.
    always_comb begin
        lock_addr    = `FWS_LOCK_ADDR;
        page         = g.addr[`FWS_ADDR_W-1:`FWS_PAGE_SHIFT];
        locked_pages = ~g.lock_byte;
        any_lock     = (locked_pages != 8'h00);
        in_low_run   = ({2'b00, page} < locked_pages);
        in_lock_page =
            (page == lock_addr[`FWS_ADDR_W-1:`FWS_PAGE_SHIFT]);
        g.allow = g.privileged
                  || !(in_low_run || (any_lock && in_lock_page));
    end

endmodule : fws_page_guard

// ==== src/fws_flash_guard.sv ====
`include "fws_map.svh"

module fws_flash_guard
    import fws_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // Special function register port
    input  wire logic                   sfr_wr,
    input  wire logic                   sfr_rd,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic [7:0]             sfr_wdata,
    output logic      [7:0]             sfr_rdata,
    // Core data-move and code-move requests
    input  wire logic                   xdata_wr,
    input  wire logic                   xdata_rd,
    input  wire logic                   code_rd,
    input  wire logic [`FWS_ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]             mem_wdata,
    input  wire logic                   code_privileged,
    // Serial debug requests, never privileged
    input  wire logic                   dbg_rd,
    input  wire logic                   dbg_wr,
    input  wire logic                   dbg_erase,
    // Flash array port
    output logic                        flash_wr,
    output logic                        flash_erase,
    output logic                        flash_rd,
    output logic      [`FWS_ADDR_W-1:0] flash_addr,
    output logic      [7:0]             flash_wdata,
    input  wire logic [7:0]             flash_rdata,
    input  wire logic                   flash_busy,
    // On-chip data RAM port
    output logic                        ram_wr,
    output logic                        ram_rd,
    output logic      [`FWS_ADDR_W-1:0] ram_addr,
    output logic      [7:0]             ram_wdata,
    // Read answer and status
    output logic      [7:0]             rd_data,
    output logic                        rd_valid,
    output logic                        access_denied,
    output logic                        lock_ready
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [7:0]             psc_reg,    psc_next;
    logic [7:0]             lock_reg,   lock_next;
    fws_state_t             st_reg,     st_next;
    logic                   frd_reg,    frd_next;
    logic                   fwr_reg,    fwr_next;
    logic                   fer_reg,    fer_next;
    logic [`FWS_ADDR_W-1:0] faddr_reg,  faddr_next;
    logic [7:0]             fwd_reg,    fwd_next;
    logic                   rwr_reg,    rwr_next;
    logic                   rrd_reg,    rrd_next;
    logic [`FWS_ADDR_W-1:0] raddr_reg,  raddr_next;
    logic [7:0]             rwd_reg,    rwd_next;
    logic [7:0]             rdat_reg,   rdat_next;
    logic                   rval_reg,   rval_next;
    logic                   den_reg,    den_next;
    logic                   pend_reg,   pend_next;
    logic                   pblk_reg,   pblk_next;
    logic [7:0]             sdat_reg,   sdat_next;
    logic                   lrdy_reg,   lrdy_next;

    logic                   we_bit;
    logic                   ee_bit;
    logic                   allow;
    logic                   is_dbg;
    logic                   want_wr;
    logic                   want_rd;
    logic                   want_er;

    fws_guard_if gi ();

    // -------------------------------------------------------------------
    // Page guard
    // -------------------------------------------------------------------
    assign gi.addr       = mem_addr;
    assign gi.lock_byte  = lock_reg;
    assign gi.privileged = code_privileged && !is_dbg;
    assign allow         = gi.allow;

    fws_page_guard u_guard (
        .g (gi.guard)
    );

    // Debug requests take the same path as the core but are never trusted.
    always_comb begin
        is_dbg  = dbg_rd || dbg_wr || dbg_erase;
        we_bit  = psc_reg[`FWS_PSC_WE_BIT];
        ee_bit  = psc_reg[`FWS_PSC_EE_BIT];
        want_wr = (xdata_wr && we_bit && !ee_bit) || dbg_wr;
        want_er = (xdata_wr && we_bit && ee_bit) || dbg_erase;
        want_rd = code_rd || dbg_rd;
    end

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    // The lock byte is fetched once after reset; until then every flash
    // request, privileged or not, is dropped without access_denied, since the
    // protection state is unknown.
    always_comb begin
        psc_next   = psc_reg;
        lock_next  = lock_reg;
        st_next    = st_reg;
        frd_next   = 1'b0;
        fwr_next   = 1'b0;
        fer_next   = 1'b0;
        faddr_next = faddr_reg;
        fwd_next   = fwd_reg;
        rwr_next   = 1'b0;
        rrd_next   = 1'b0;
        raddr_next = raddr_reg;
        rwd_next   = rwd_reg;
        rdat_next  = rdat_reg;
        rval_next  = 1'b0;
        den_next   = 1'b0;
        pend_next  = 1'b0;
        pblk_next  = 1'b0;
        sdat_next  = sdat_reg;
        if (sfr_wr && sfr_addr == `FWS_PSC_ADDR) begin
            psc_next = sfr_wdata;
        end
        if (sfr_rd && sfr_addr == `FWS_PSC_ADDR) begin
            sdat_next = psc_reg;
        end
        unique case (st_reg)
            FWS_ST_FETCH: begin
                frd_next   = 1'b1;
                faddr_next = `FWS_LOCK_ADDR;
                st_next    = FWS_ST_WAIT;
            end
            FWS_ST_WAIT: begin
                lock_next = flash_rdata;
                st_next   = FWS_ST_RUN;
            end
            FWS_ST_RUN: begin
                // Data-move traffic other than flash writes lands in RAM.
                if (xdata_rd || (xdata_wr && !we_bit)) begin
                    rrd_next   = xdata_rd;
                    rwr_next   = xdata_wr && !xdata_rd;
                    raddr_next = mem_addr;
                    rwd_next   = mem_wdata;
                end
                if (!flash_busy && (want_wr || want_er)) begin
                    if (allow) begin
                        fwr_next   = want_wr;
                        fer_next   = want_er;
                        faddr_next = mem_addr;
                        fwd_next   = mem_wdata;
                    end else begin
                        den_next = 1'b1;
                    end
                end else if (want_rd && !want_wr && !want_er) begin
                    frd_next   = 1'b1;
                    faddr_next = mem_addr;
                    pend_next  = 1'b1;
                    pblk_next  = !allow;
                end
            end
        endcase
        // Read answer one cycle after the flash read strobe.
        if (pend_reg) begin
            rval_next = 1'b1;
            rdat_next = pblk_reg ? `FWS_BLOCKED_READ : flash_rdata;
            den_next  = den_next || pblk_reg;
        end
        // Ready is registered so the status pin comes from a flop.
        lrdy_next = (st_next == FWS_ST_RUN);
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            psc_reg   <= `FWS_PSC_RESET;
            lock_reg  <= 8'h00;
            st_reg    <= FWS_ST_FETCH;
            frd_reg   <= 1'b0;
            fwr_reg   <= 1'b0;
            fer_reg   <= 1'b0;
            faddr_reg <= '0;
            fwd_reg   <= 8'h00;
            rwr_reg   <= 1'b0;
            rrd_reg   <= 1'b0;
            raddr_reg <= '0;
            rwd_reg   <= 8'h00;
            rdat_reg  <= 8'h00;
            rval_reg  <= 1'b0;
            den_reg   <= 1'b0;
            pend_reg  <= 1'b0;
            pblk_reg  <= 1'b0;
            sdat_reg  <= 8'h00;
            lrdy_reg  <= 1'b0;
        end else begin
            psc_reg   <= psc_next;
            lock_reg  <= lock_next;
            st_reg    <= st_next;
            frd_reg   <= frd_next;
            fwr_reg   <= fwr_next;
            fer_reg   <= fer_next;
            faddr_reg <= faddr_next;
            fwd_reg   <= fwd_next;
            rwr_reg   <= rwr_next;
            rrd_reg   <= rrd_next;
            raddr_reg <= raddr_next;
            rwd_reg   <= rwd_next;
            rdat_reg  <= rdat_next;
            rval_reg  <= rval_next;
            den_reg   <= den_next;
            pend_reg  <= pend_next;
            pblk_reg  <= pblk_next;
            sdat_reg  <= sdat_next;
            lrdy_reg  <= lrdy_next;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign sfr_rdata     = sdat_reg;
    assign flash_wr      = fwr_reg;
    assign flash_erase   = fer_reg;
    assign flash_rd      = frd_reg;
    assign flash_addr    = faddr_reg;
    assign flash_wdata   = fwd_reg;
    assign ram_wr        = rwr_reg;
    assign ram_rd        = rrd_reg;
    assign ram_addr      = raddr_reg;
    assign ram_wdata     = rwd_reg;
    assign rd_data       = rdat_reg;
    assign rd_valid      = rval_reg;
    assign access_denied = den_reg;
    assign lock_ready    = lrdy_reg;

endmodule : fws_flash_guard

// ==== verif/fws_flash_guard_monitor.sv ====
`include "fws_map.svh"

// ----
// Guard checker
// ----
module fws_flash_guard_monitor
    import fws_pkg::*;
#(
    parameter int LOCKED = 2
)(
    // Clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // Core and debug requests
    input wire logic        xdata_rd,
    input wire logic        xdata_wr,
    input wire logic        code_rd,
    input wire logic        dbg_rd,
    input wire logic        dbg_wr,
    input wire logic        dbg_erase,
    input wire logic [14:0] mem_addr,
    // Flash, RAM and answer side
    input wire logic        flash_wr,
    input wire logic        flash_erase,
    input wire logic        flash_rd,
    input wire logic        flash_busy,
    input wire logic        ram_rd,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_valid,
    input wire logic        access_denied,
    input wire logic        lock_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] pg;
    logic       lk;

    // The lock byte page counts as locked whenever lower pages are.
    assign pg = mem_addr[14:9];
    assign lk = (pg < LOCKED) || (pg == 6'h3F && LOCKED > 0);

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    xrd_ram_a: assert property (xdata_rd |=> ram_rd && !flash_rd)
        else $error("data read not sent to RAM");
    code_ans_a: assert property (code_rd |=> ##1 rd_valid)
        else $error("code read gave no answer");
    wr_cause_a: assert property (flash_wr |-> $past(xdata_wr || dbg_wr))
        else $error("flash write without request");
    er_cause_a: assert property
        (flash_erase |-> $past(xdata_wr || dbg_erase))
        else $error("flash erase without request");
    deny_zero_a: assert property
        (rd_valid && access_denied |-> rd_data == 8'h00)
        else $error("refused read leaked data");
    dbg_lock_a: assert property
        (dbg_rd && lock_ready && lk |=> ##1 rd_valid && access_denied)
        else $error("locked page read by debug");
    lock_page_a: assert property
        (dbg_rd && lock_ready && pg == 6'h3F |=> ##1 access_denied)
        else $error("lock byte page open");
    dbg_open_a: assert property
        (dbg_rd && lock_ready && !lk |=> ##1 !access_denied)
        else $error("open page refused");
    wr_block_a: assert property
        (dbg_wr && lock_ready && lk && !flash_busy
         |=> !flash_wr && access_denied)
        else $error("locked page written");

    cover property (rd_valid && access_denied);
    cover property (flash_erase);
    cover property (ram_rd);
endmodule : fws_flash_guard_monitor

bind fws_flash_guard fws_flash_guard_monitor #(.LOCKED(2))
    fws_flash_guard_monitor_inst (.clock, .sys_rst, .xdata_rd, .xdata_wr,
    .code_rd, .dbg_rd, .dbg_wr, .dbg_erase, .mem_addr, .flash_wr,
    .flash_erase, .flash_rd, .flash_busy, .ram_rd, .rd_data, .rd_valid,
    .access_denied, .lock_ready);

// ==== verif/fws_flash_model.sv ====
// ----
// Flash array model
// ----
module fws_flash_model #(
    parameter logic [7:0] LOCK_BYTE = 8'hFD
)(
    input  wire logic        clock,
    input  wire logic        flash_wr,
    input  wire logic        flash_erase,
    input  wire logic        flash_rd,
    input  wire logic [14:0] flash_addr,
    input  wire logic [7:0]  flash_wdata,
    output logic      [7:0]  flash_rdata,
    output logic             flash_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:32767];
    logic [7:0] junk;
    logic [1:0] busy_cnt;

    // Known pattern; the lock byte sits in the last byte.
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
        mem[32767] = LOCK_BYTE;
        junk = 8'hA5;
        busy_cnt = 2'h0;
    end

    // Idle data toggles so a stale value never looks valid.
    assign flash_rdata = flash_rd ? mem[flash_addr] : junk;
    assign flash_busy = busy_cnt != 2'h0;

    // Array updates; each program or erase keeps the array busy.
    always @(posedge clock) begin
        junk <= ~junk;
        if (flash_wr) begin
            mem[flash_addr] <= flash_wdata;
        end
        if (flash_erase) begin
            for (int i = 0; i < 512; i++) begin
                mem[{flash_addr[14:9], i[8:0]}] <= 8'hFF;
            end
        end
        busy_cnt <= (flash_wr || flash_erase) ? 2'h2 :
                    busy_cnt - {1'b0, flash_busy};
    end
endmodule : fws_flash_model

// ==== verif/fws_flash_guard_bench.sv ====
`include "fws_map.svh"

module fws_flash_guard_bench
    import fws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] k; logic [14:0] a; logic p; logic [7:0] d; logic dn;
    } fws_row_t;
    logic clock, sys_rst, sfr_wr, sfr_rd, xdata_wr, xdata_rd, code_rd;
    logic code_privileged, dbg_rd, dbg_wr, dbg_erase, flash_wr;
    logic flash_erase, flash_rd, flash_busy, ram_wr, ram_rd;
    logic rd_valid, access_denied, lock_ready;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, mem_wdata, flash_wdata;
    logic [7:0] flash_rdata, ram_wdata, rd_data;
    logic [14:0] mem_addr, flash_addr, ram_addr;
    int n_fail, tests_run;
    // Pages 0 and 1 plus the lock byte page are locked.
    fws_row_t rows [8] = '{
        '{3'h0, 15'h0000, 1'b0, 8'h00, 1'b1},
        '{3'h0, 15'h0000, 1'b1, 8'h5A, 1'b0},
        '{3'h0, 15'h03FF, 1'b0, 8'h00, 1'b1},
        '{3'h0, 15'h0400, 1'b0, 8'h5A, 1'b0},
        '{3'h1, 15'h0200, 1'b0, 8'h00, 1'b1},
        '{3'h1, 15'h7DFF, 1'b0, 8'hA5, 1'b0},
        '{3'h1, 15'h7E00, 1'b0, 8'h00, 1'b1},
        '{3'h0, 15'h7FFF, 1'b1, 8'hFD, 1'b0}};

    fws_flash_guard fws_flash_guard_inst (.clock, .sys_rst, .sfr_wr,
        .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .xdata_wr, .xdata_rd,
        .code_rd, .mem_addr, .mem_wdata, .code_privileged, .dbg_rd,
        .dbg_wr, .dbg_erase, .flash_wr, .flash_erase, .flash_rd,
        .flash_addr, .flash_wdata, .flash_rdata, .flash_busy, .ram_wr,
        .ram_rd, .ram_addr, .ram_wdata, .rd_data, .rd_valid,
        .access_denied, .lock_ready);
    fws_flash_model fws_flash_model_inst (.clock, .flash_wr, .flash_erase,
        .flash_rd, .flash_addr, .flash_wdata, .flash_rdata, .flash_busy);

    // Clock of 100 ns period.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic summarize();
        $display("mismatches %0d, compares %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One register access; read data is seen the cycle after.
    task automatic sfr(logic w, logic [7:0] a, logic [7:0] d);
        @(negedge clock);
        {sfr_wr, sfr_rd} = {w, !w};
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clock);
        {sfr_wr, sfr_rd} = 2'h0;
    endtask : sfr

    // One memory request, held for a single cycle.
    task automatic req(logic [2:0] k, logic [14:0] a, logic [7:0] d,
                       logic p);
        @(negedge clock);
        {code_rd, dbg_rd, xdata_wr, xdata_rd, dbg_wr} =
            5'h10 >> k;
        mem_addr = a;
        mem_wdata = d;
        code_privileged = p;
        @(negedge clock);
        {code_rd, dbg_rd, xdata_wr, xdata_rd, dbg_wr} = 5'h0;
    endtask : req

    // Read and compare the answer, bounded wait for its valid pulse.
    task automatic rd_chk(logic [2:0] k, logic [14:0] a, logic p,
                          logic [7:0] d, logic dn);
        int i;
        req(k, a, 8'h00, p);
        for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, d);
        chk({7'h00, access_denied}, {7'h00, dn});
        repeat (3) @(negedge clock);
    endtask : rd_chk

    // Watchdog well beyond the expected run.
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        summarize();
    end

    // Main sequence.
    initial begin
        {sfr_wr, sfr_rd, xdata_wr, xdata_rd, code_rd, dbg_rd} = 6'h0;
        {code_privileged, dbg_wr, dbg_erase} = 3'h0;
        {sfr_addr, sfr_wdata, mem_wdata, mem_addr} = 39'h0;
        n_fail = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        repeat (16) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        chk({7'h00, lock_ready}, 8'h01);
        sfr(1'b0, 8'h8F, 8'h00);
        chk(sfr_rdata, 8'h00);
        foreach (rows[j]) begin
            rd_chk(rows[j].k, rows[j].a, rows[j].p, rows[j].d,
                   rows[j].dn);
        end
        sfr(1'b1, 8'h8F, 8'h03);
        req(3'h3, 15'h0800, 8'h00, 1'b0);
        chk({6'h00, ram_rd, flash_rd}, 8'h02);
        chk({1'b0, ram_addr[14:8]}, 8'h08);
        sfr(1'b1, 8'h8F, 8'h00);
        req(3'h2, 15'h0800, 8'h33, 1'b0);
        chk({6'h00, ram_wr, flash_wr}, 8'h02);
        chk(ram_wdata, 8'h33);
        rd_chk(3'h0, 15'h0800, 1'b0, 8'h5A, 1'b0);
        sfr(1'b1, 8'h8F, 8'h01);
        sfr(1'b1, 8'h8E, 8'h00);
        sfr(1'b0, 8'h8F, 8'h00);
        chk(sfr_rdata, 8'h01);
        req(3'h2, 15'h0800, 8'h33, 1'b0);
        chk({7'h00, flash_wr}, 8'h01);
        rd_chk(3'h0, 15'h0800, 1'b0, 8'h33, 1'b0);
        req(3'h2, 15'h0000, 8'h77, 1'b0);
        chk({6'h00, flash_wr, access_denied}, 8'h01);
        req(3'h4, 15'h0200, 8'h77, 1'b0);
        chk({6'h00, flash_wr, access_denied}, 8'h01);
        // Debug erase of a locked page is refused whatever the enables.
        @(negedge clock);
        {dbg_erase, mem_addr} = {1'b1, 15'h0000};
        @(negedge clock);
        dbg_erase = 1'b0;
        chk({6'h00, flash_erase, access_denied}, 8'h01);
        rd_chk(3'h0, 15'h0000, 1'b1, 8'h5A, 1'b0);
        sfr(1'b1, 8'h8F, 8'h03);
        req(3'h2, 15'h0810, 8'h00, 1'b0);
        chk({7'h00, flash_erase}, 8'h01);
        rd_chk(3'h0, 15'h0800, 1'b0, 8'hFF, 1'b0);
        sfr(1'b1, 8'h8F, 8'h02);
        req(3'h2, 15'h0A00, 8'h11, 1'b0);
        chk({6'h00, flash_erase, ram_wr}, 8'h01);
        rd_chk(3'h0, 15'h0A00, 1'b0, 8'h5A, 1'b0);
        summarize();
    end
endmodule : fws_flash_guard_bench
